/* src/wedc_consts.svh */
// Constants for the word EDAC host controller.
`ifndef WEDC_CONSTS_SVH
`define WEDC_CONSTS_SVH

// Register byte offsets on the APB port.
`define WEDC_OFF_CTRL 8'h00
`define WEDC_OFF_WDATA 8'h04
`define WEDC_OFF_WCHECK 8'h08
`define WEDC_OFF_STATUS 8'h0C
`define WEDC_OFF_RDATA 8'h10
`define WEDC_OFF_RCHECK 8'h14
`define WEDC_OFF_DDATA 8'h18

// Control register fields.
`define WEDC_CTRL_CMD_LSB 0
`define WEDC_CTRL_CMD_MSB 2
`define WEDC_CTRL_MASK_LSB 4
`define WEDC_CTRL_MASK_MSB 7

// Status register fields.
`define WEDC_ST_BUSY 0
`define WEDC_ST_DONE 1
`define WEDC_ST_CORR 2
`define WEDC_ST_UNCORR 3
`define WEDC_ST_DSINGLE 4
`define WEDC_ST_DMULTI 5

// Reset values.
`define WEDC_RST_WORD 32'h0000_0000
`define WEDC_RST_CHECK 7'h00

// Timing: the settle time covers the device's slowest path, then the pin synchroniser.
`define WEDC_CLK_PERIOD_PS 4000
`define WEDC_SETTLE_NS 40
`define WEDC_SYNC_LAT 4
`define WEDC_SETTLE_CYC ((`WEDC_SETTLE_NS * 1000 + `WEDC_CLK_PERIOD_PS - 1) / `WEDC_CLK_PERIOD_PS + `WEDC_SYNC_LAT)

`endif

/* src/wedc_pkg.sv */
// Types shared by the word EDAC host controller.
package wedc_pkg;

    typedef enum logic [2:0] {
        WEDC_CMD_NONE = 3'h0,
        WEDC_CMD_READ = 3'h1,
        WEDC_CMD_WRITE = 3'h2,
        WEDC_CMD_RMW = 3'h3,
        WEDC_CMD_DIAG = 3'h4
    } wedc_cmd_t;

    typedef enum logic [6:0] {
        WEDC_ST_IDLE = 7'b000_0001,
        WEDC_ST_FLAG = 7'b000_0010,
        WEDC_ST_LATCH = 7'b000_0100,
        WEDC_ST_LOAD = 7'b000_1000,
        WEDC_ST_MODIFY = 7'b001_0000,
        WEDC_ST_GEN = 7'b010_0000,
        WEDC_ST_DIAG = 7'b100_0000
    } wedc_state_t;

endpackage : wedc_pkg

/* src/wedc_sync.sv */
// Three-stage pin synchroniser with a second/third stage agreement filter.
`timescale 1ns/1ps
`default_nettype none

module wedc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Pins and filtered result
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] value_nxt;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("wedc_sync needs WIDTH of at least one");
        end
    endgenerate

    // A bit takes its new level only once the second and third stages agree.
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            value_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : value[i];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            value <= '0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            value <= value_nxt;
        end
    end

endmodule : wedc_sync
`default_nettype wire

/* src/wedc_ctrl.sv */
// Host controller that sequences a 32-bit word EDAC through its pins under APB control.
`timescale 1ns/1ps
`default_nettype none
`include "wedc_consts.svh"

// Summary of operation
// - Read-and-flag then latch-input select order captures the 39-bit word.
// - Output data latch loads on a low-to-high edge of its latch enable.
// - High byte enable frees the lane for the host; low drives original byte.
// - After modifying bytes, both selects go low to generate a new check word.
// - Diagnostic then correction mode corrects the diagnostic word with syndrome.
// - Single flag low with multi high: run the correction cycle before use.
// - Both flags low is uncorrectable; the read data must not be used.
module wedc_ctrl #(
    parameter int SETTLE_CYC = `WEDC_SETTLE_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device control pins
    output logic function_select_low,
    output logic function_select_high,
    output logic data_out_latch_load,
    output logic [3:0] byte_lane_output_enable_n,
    output logic check_port_output_enable_n,
    // Device data and check ports, split into in, out and enable
    input wire logic [31:0] data_bit_port_in,
    output logic [31:0] data_bit_port_out,
    output logic [31:0] data_bit_port_oe,
    input wire logic [6:0] check_bit_port_in,
    output logic [6:0] check_bit_port_out,
    output logic [6:0] check_bit_port_oe,
    // Device error flags
    input wire logic single_error_flag_n,
    input wire logic multi_error_flag_n
);

    generate
        if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
            $error("wedc_ctrl SETTLE_CYC must lie in 1 to 255");
        end
    endgenerate

    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

    // Synchronised pins.
    logic [31:0] data_s;
    logic [6:0] check_s;
    logic serr_n_s;
    logic multi_error_flag_n_n_s;

    wedc_sync #(.WIDTH(41)) u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin({multi_error_flag_n, single_error_flag_n, check_bit_port_in, data_bit_port_in}),
        .value({multi_error_flag_n_n_s, serr_n_s, check_s, data_s})
    );

    // Sequencer and software-visible state.
    wedc_pkg::wedc_state_t state_r, state_nxt;
    wedc_pkg::wedc_cmd_t cmd_r, cmd_nxt;
    logic [7:0] timer_r, timer_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [6:0] wcheck_r, wcheck_nxt;
    logic [31:0] ddata_r, ddata_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [6:0] rcheck_r, rcheck_nxt;
    logic done_r, done_nxt;
    logic corr_r, corr_nxt;
    logic uncorr_r, uncorr_nxt;
    logic dsingle_r, dsingle_nxt;
    logic dmulti_r, dmulti_nxt;
    logic wr_acc;
    logic start;
    logic [31:0] status_w;

    assign wr_acc = psel && penable && pwrite && pready && (state_r == wedc_pkg::WEDC_ST_IDLE);
    assign start = wr_acc && (paddr == `WEDC_OFF_CTRL);

    always_comb begin
        status_w = 32'h0000_0000;
        status_w[`WEDC_ST_BUSY] = (state_r != wedc_pkg::WEDC_ST_IDLE);
        status_w[`WEDC_ST_DONE] = done_r;
        status_w[`WEDC_ST_CORR] = corr_r;
        status_w[`WEDC_ST_UNCORR] = uncorr_r;
        status_w[`WEDC_ST_DSINGLE] = dsingle_r;
        status_w[`WEDC_ST_DMULTI] = dmulti_r;
    end

    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        mask_nxt = mask_r;
        timer_nxt = (timer_r != 8'h00) ? timer_r - 8'h01 : 8'h00;
        wdata_nxt = wdata_r;
        wcheck_nxt = wcheck_r;
        ddata_nxt = ddata_r;
        rdata_nxt = rdata_r;
        rcheck_nxt = rcheck_r;
        done_nxt = done_r;
        corr_nxt = corr_r;
        uncorr_nxt = uncorr_r;
        dsingle_nxt = dsingle_r;
        dmulti_nxt = dmulti_r;
        if (wr_acc && paddr == `WEDC_OFF_WDATA) begin
            wdata_nxt = pwdata;
        end
        if (wr_acc && paddr == `WEDC_OFF_WCHECK) begin
            wcheck_nxt = pwdata[6:0];
        end
        if (wr_acc && paddr == `WEDC_OFF_DDATA) begin
            ddata_nxt = pwdata;
        end
        unique case (state_r)
            wedc_pkg::WEDC_ST_IDLE: begin
                if (start) begin
                    cmd_nxt = wedc_pkg::wedc_cmd_t'(pwdata[`WEDC_CTRL_CMD_MSB:`WEDC_CTRL_CMD_LSB]);
                    mask_nxt = pwdata[`WEDC_CTRL_MASK_MSB:`WEDC_CTRL_MASK_LSB];
                    done_nxt = 1'b0;
                    corr_nxt = 1'b0;
                    uncorr_nxt = 1'b0;
                    dsingle_nxt = 1'b0;
                    dmulti_nxt = 1'b0;
                    timer_nxt = SETTLE_LOAD;
                    if (pwdata[`WEDC_CTRL_CMD_MSB:`WEDC_CTRL_CMD_LSB] == wedc_pkg::WEDC_CMD_WRITE) begin
                        state_nxt = wedc_pkg::WEDC_ST_GEN;
                    end else if (pwdata[`WEDC_CTRL_CMD_MSB:`WEDC_CTRL_CMD_LSB] == wedc_pkg::WEDC_CMD_NONE
                        || pwdata[`WEDC_CTRL_CMD_MSB:`WEDC_CTRL_CMD_LSB] > wedc_pkg::WEDC_CMD_DIAG) begin
                        done_nxt = 1'b1;
                    end else begin
                        state_nxt = wedc_pkg::WEDC_ST_FLAG;
                    end
                end
            end
            wedc_pkg::WEDC_ST_FLAG: begin
                if (timer_r == 8'h00) begin
                    timer_nxt = SETTLE_LOAD;
                    if (cmd_r == wedc_pkg::WEDC_CMD_DIAG) begin
                        state_nxt = wedc_pkg::WEDC_ST_DIAG;
                    end else if (!serr_n_s && !multi_error_flag_n_n_s) begin
                        uncorr_nxt = 1'b1;
                        done_nxt = 1'b1;
                        state_nxt = wedc_pkg::WEDC_ST_IDLE;
                    end else if (!serr_n_s || cmd_r == wedc_pkg::WEDC_CMD_RMW) begin
                        corr_nxt = !serr_n_s;
                        state_nxt = wedc_pkg::WEDC_ST_LATCH;
                    end else begin
                        rdata_nxt = data_s;
                        rcheck_nxt = check_s;
                        done_nxt = 1'b1;
                        state_nxt = wedc_pkg::WEDC_ST_IDLE;
                    end
                end
            end
            wedc_pkg::WEDC_ST_DIAG: begin
                if (timer_r == 8'h00) begin
                    dsingle_nxt = !serr_n_s;
                    dmulti_nxt = !multi_error_flag_n_n_s;
                    rcheck_nxt = check_s;
                    timer_nxt = SETTLE_LOAD;
                    state_nxt = wedc_pkg::WEDC_ST_LATCH;
                end
            end
            wedc_pkg::WEDC_ST_LATCH: begin
                if (timer_r == 8'h00) begin
                    timer_nxt = SETTLE_LOAD;
                    state_nxt = wedc_pkg::WEDC_ST_LOAD;
                end
            end
            wedc_pkg::WEDC_ST_LOAD: begin
                if (timer_r == 8'h00) begin
                    rdata_nxt = data_s;
                    rcheck_nxt = check_s;
                    timer_nxt = SETTLE_LOAD;
                    if (cmd_r == wedc_pkg::WEDC_CMD_RMW) begin
                        state_nxt = wedc_pkg::WEDC_ST_MODIFY;
                    end else begin
                        done_nxt = 1'b1;
                        state_nxt = wedc_pkg::WEDC_ST_IDLE;
                    end
                end
            end
            wedc_pkg::WEDC_ST_MODIFY, wedc_pkg::WEDC_ST_GEN: begin
                if (timer_r == 8'h00) begin
                    rdata_nxt = data_s;
                    rcheck_nxt = check_s;
                    done_nxt = 1'b1;
                    state_nxt = wedc_pkg::WEDC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = wedc_pkg::WEDC_ST_IDLE;
            end
        endcase
    end

    // Pin levels are decoded from the next state so that every pin leaves a flip-flop.
    logic s_low_nxt, s_high_nxt, latch_load_nxt, cpoe_n_nxt;
    logic [3:0] lane_oe_n_nxt;
    logic [31:0] dout_nxt, doe_nxt;
    logic [6:0] cout_nxt, coe_nxt;

    always_comb begin
        s_high_nxt = 1'b1;
        s_low_nxt = 1'b0;
        latch_load_nxt = 1'b0;
        lane_oe_n_nxt = 4'hF;
        cpoe_n_nxt = 1'b1;
        dout_nxt = 32'h0000_0000;
        doe_nxt = 32'h0000_0000;
        cout_nxt = 7'h00;
        coe_nxt = 7'h00;
        unique case (state_nxt)
            wedc_pkg::WEDC_ST_IDLE: begin
            end
            wedc_pkg::WEDC_ST_FLAG: begin
                // Read-and-flag first; the memory drives both ports on a read.
                if (cmd_nxt == wedc_pkg::WEDC_CMD_DIAG) begin
                    dout_nxt = wdata_nxt;
                    doe_nxt = 32'hFFFF_FFFF;
                    cout_nxt = wcheck_nxt;
                    coe_nxt = 7'h7F;
                end
            end
            wedc_pkg::WEDC_ST_DIAG: begin
                s_high_nxt = 1'b0;
                s_low_nxt = 1'b1;
                cpoe_n_nxt = 1'b0;
                dout_nxt = ddata_nxt;
                doe_nxt = 32'hFFFF_FFFF;
            end
            wedc_pkg::WEDC_ST_LATCH: begin
                s_low_nxt = 1'b1;
                if (cmd_nxt == wedc_pkg::WEDC_CMD_DIAG) begin
                    dout_nxt = ddata_nxt;
                    doe_nxt = 32'hFFFF_FFFF;
                end
            end
            wedc_pkg::WEDC_ST_LOAD: begin
                s_low_nxt = 1'b1;
                latch_load_nxt = 1'b1;
                lane_oe_n_nxt = 4'h0;
                cpoe_n_nxt = 1'b0;
            end
            wedc_pkg::WEDC_ST_MODIFY: begin
                s_high_nxt = 1'b0;
                latch_load_nxt = 1'b1;
                lane_oe_n_nxt = mask_nxt;
                cpoe_n_nxt = 1'b0;
                dout_nxt = wdata_nxt;
                for (int b = 0; b < 4; b++) begin
                    doe_nxt[b*8 +: 8] = {8{mask_nxt[b]}};
                end
            end
            wedc_pkg::WEDC_ST_GEN: begin
                s_high_nxt = 1'b0;
                cpoe_n_nxt = 1'b0;
                dout_nxt = wdata_nxt;
                doe_nxt = 32'hFFFF_FFFF;
            end
            default: begin
            end
        endcase
    end

    // APB answers one cycle after setup, so every access completes with no wait state.
    logic pready_nxt, pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic mapped;

    always_comb begin
        mapped = 1'b1;
        prdata_nxt = 32'h0000_0000;
        unique case (paddr)
            `WEDC_OFF_CTRL: prdata_nxt = {24'h00_0000, mask_r, 1'b0, cmd_r};
            `WEDC_OFF_WDATA: prdata_nxt = wdata_r;
            `WEDC_OFF_WCHECK: prdata_nxt = {25'h000_0000, wcheck_r};
            `WEDC_OFF_STATUS: prdata_nxt = status_w;
            `WEDC_OFF_RDATA: prdata_nxt = rdata_r;
            `WEDC_OFF_RCHECK: prdata_nxt = {25'h000_0000, rcheck_r};
            `WEDC_OFF_DDATA: prdata_nxt = ddata_r;
            default: mapped = 1'b0;
        endcase
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && (!mapped || (pwrite
            && (paddr == `WEDC_OFF_STATUS || paddr == `WEDC_OFF_RDATA || paddr == `WEDC_OFF_RCHECK)));
        if (!(psel && !penable && !pwrite)) begin
            prdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= wedc_pkg::WEDC_ST_IDLE;
            cmd_r <= wedc_pkg::WEDC_CMD_NONE;
            mask_r <= 4'h0;
            timer_r <= 8'h00;
            wdata_r <= `WEDC_RST_WORD;
            wcheck_r <= `WEDC_RST_CHECK;
            ddata_r <= `WEDC_RST_WORD;
            rdata_r <= `WEDC_RST_WORD;
            rcheck_r <= `WEDC_RST_CHECK;
            done_r <= 1'b0;
            corr_r <= 1'b0;
            uncorr_r <= 1'b0;
            dsingle_r <= 1'b0;
            dmulti_r <= 1'b0;
            function_select_high <= 1'b1;
            function_select_low <= 1'b0;
            data_out_latch_load <= 1'b0;
            byte_lane_output_enable_n <= 4'hF;
            check_port_output_enable_n <= 1'b1;
            data_bit_port_out <= 32'h0000_0000;
            data_bit_port_oe <= 32'h0000_0000;
            check_bit_port_out <= 7'h00;
            check_bit_port_oe <= 7'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            mask_r <= mask_nxt;
            timer_r <= timer_nxt;
            wdata_r <= wdata_nxt;
            wcheck_r <= wcheck_nxt;
            ddata_r <= ddata_nxt;
            rdata_r <= rdata_nxt;
            rcheck_r <= rcheck_nxt;
            done_r <= done_nxt;
            corr_r <= corr_nxt;
            uncorr_r <= uncorr_nxt;
            dsingle_r <= dsingle_nxt;
            dmulti_r <= dmulti_nxt;
            function_select_high <= s_high_nxt;
            function_select_low <= s_low_nxt;
            data_out_latch_load <= latch_load_nxt;
            byte_lane_output_enable_n <= lane_oe_n_nxt;
            check_port_output_enable_n <= cpoe_n_nxt;
            data_bit_port_out <= dout_nxt;
            data_bit_port_oe <= doe_nxt;
            check_bit_port_out <= cout_nxt;
            check_bit_port_oe <= coe_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

endmodule : wedc_ctrl
`default_nettype wire

/* tb/wedc_ctrl_asserts.sv */
// Pin and bus checker for the word EDAC host controller.
`timescale 1ns/1ps
`default_nettype none

module wedc_ctrl_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Device pins
    input wire logic function_select_low,
    input wire logic function_select_high,
    input wire logic data_out_latch_load,
    input wire logic [3:0] byte_lane_output_enable_n,
    input wire logic check_port_output_enable_n,
    input wire logic [31:0] data_bit_port_oe,
    input wire logic [6:0] check_bit_port_oe
);
    logic [31:0] lane_oe;
    logic fsh;
    logic fsl;

    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    assign fsh = function_select_high;
    assign fsl = function_select_low;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            lane_oe[i] = byte_lane_output_enable_n[i / 8];
        end
    end

    property p_zero_wait; psel && !penable |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    property p_no_clash; |data_bit_port_oe |-> (data_bit_port_oe & ~lane_oe) == 32'h0000_0000;
    endproperty
    property p_gen_mode;
        !fsh && !fsl |-> data_bit_port_oe == lane_oe && !check_port_output_enable_n
            && check_bit_port_oe == 7'h00;
    endproperty
    property p_load_rise; $rose(data_out_latch_load) |-> fsh && fsl && $past(fsh && fsl);
    endproperty
    property p_latch_order; $rose(fsl) && fsh |-> $past(fsh) ##0 (fsh && fsl) [*3]; endproperty
    property p_lanes_loaded; !(&byte_lane_output_enable_n) |-> data_out_latch_load; endproperty
    property p_diag_mode;
        fsl && !fsh |-> data_bit_port_oe == 32'hFFFF_FFFF && check_bit_port_oe == 7'h00;
    endproperty

    a_zero_wait: assert property (p_zero_wait) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready stuck");
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
    a_no_clash: assert property (p_no_clash) else $error("data lane clash");
    a_gen_mode: assert property (p_gen_mode) else $error("bad generate pins");
    a_load_rise: assert property (p_load_rise) else $error("bad load edge");
    a_latch_order: assert property (p_latch_order) else $error("bad select order");
    a_lanes_loaded: assert property (p_lanes_loaded) else $error("lane before load");
    a_diag_mode: assert property (p_diag_mode) else $error("bad diag pins");

    c_load: cover property ($rose(data_out_latch_load));
    c_merge: cover property (!fsh && !fsl && byte_lane_output_enable_n != 4'hF);
    c_err: cover property (pslverr);
    c_diag: cover property (fsl && !fsh);
endmodule : wedc_ctrl_asserts

bind wedc_ctrl wedc_ctrl_asserts i_chk (.*);

`default_nettype wire

/* tb/wedc_edac_model.sv */
// Behavioural word EDAC device with its memory on the far side of the controller.
`timescale 1ns/1ps
`default_nettype none

module wedc_edac_model (
    // Device control pins
    input wire logic function_select_low,
    input wire logic function_select_high,
    input wire logic data_out_latch_load,
    input wire logic [3:0] byte_lane_output_enable_n,
    input wire logic check_port_output_enable_n,
    // Host drive of the two-way ports
    input wire logic [31:0] data_bit_port_out,
    input wire logic [31:0] data_bit_port_oe,
    input wire logic [6:0] check_bit_port_out,
    input wire logic [6:0] check_bit_port_oe,
    // Memory word and pattern for undriven lines
    input wire logic [31:0] mem_data,
    input wire logic [6:0] mem_check,
    input wire logic [31:0] float_pat,
    // Resolved buses and flags
    output logic [31:0] data_bit_port_in,
    output logic [6:0] check_bit_port_in,
    output logic single_error_flag_n,
    output logic multi_error_flag_n
);
    logic [6:0] col [32];
    logic [31:0] dl, corr, olat, dev_oe;
    logic [6:0] cl, diff, dev_c;
    logic sh, sl, mem_on, gen_mode;
    int n;

    // Each data bit feeds the three groups set in its column.
    initial begin
        n = 0;
        for (int v = 0; v < 128; v++) begin
            if ($countones(v) == 3 && n < 32) begin
                col[n] = v[6:0];
                n++;
            end
        end
    end

    // The offset keeps an all-zero memory word from reading as clean.
    function automatic logic [6:0] gen(input logic [31:0] d);
        logic [6:0] c;
        c = 7'h0A;
        for (int i = 0; i < 32; i++) begin
            if (d[i]) begin
                c ^= col[i];
            end
        end
        return c;
    endfunction : gen

    assign sh = function_select_high;
    assign sl = function_select_low;
    assign mem_on = sh && !sl;
    assign gen_mode = !sh && !sl;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            dev_oe[i] = !byte_lane_output_enable_n[i / 8];
        end
    end
    // Memory answers only in read-and-flag; a released line shows a moving pattern.
    assign data_bit_port_in = (data_bit_port_oe & data_bit_port_out) | (dev_oe & olat)
        | (~data_bit_port_oe & ~dev_oe & (mem_on ? mem_data : float_pat));
    always @(*) begin
        if (!(sh && sl)) begin
            dl = data_bit_port_in;
        end
        if (!sl) begin
            cl = check_bit_port_in;
        end
    end
    assign diff = cl ^ gen(dl);
    always_comb begin
        corr = dl;
        for (int i = 0; i < 32; i++) begin
            if (diff == col[i]) begin
                corr[i] = !dl[i];
            end
        end
    end
    always @(posedge data_out_latch_load) begin
        olat <= corr;
    end
    always_comb begin
        case ({sh, sl})
            2'b00: dev_c = gen(data_bit_port_in);
            2'b01: dev_c = cl;
            default: dev_c = ~diff;
        endcase
    end
    assign check_bit_port_in = (check_bit_port_oe & check_bit_port_out) | (~check_bit_port_oe
        & (check_port_output_enable_n ? (mem_on ? mem_check : float_pat[6:0]) : dev_c));
    // Odd failing groups: one bad bit; even nonzero: two.
    assign single_error_flag_n = gen_mode || diff == 7'h00;
    assign multi_error_flag_n = gen_mode || $countones(diff) % 2 == 1 || diff == 7'h00;
endmodule : wedc_edac_model

`default_nettype wire

/* tb/wedc_ctrl_tb_top.sv */
// Self-checking testbench for the word EDAC host controller.
`timescale 1ns/1ps
`default_nettype none
`include "wedc_consts.svh"

module wedc_ctrl_tb_top;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, good, wd, exp_d;
    logic function_select_low, function_select_high, data_out_latch_load;
    logic check_port_output_enable_n, single_error_flag_n, multi_error_flag_n;
    logic [3:0] byte_lane_output_enable_n, m;
    logic [3:0] st_tab [5] = '{4'h2, 4'h6, 4'h6, 4'hA, 4'hA};
    logic [31:0] data_bit_port_in, data_bit_port_out, data_bit_port_oe;
    logic [6:0] check_bit_port_in, check_bit_port_out, check_bit_port_oe, ec;
    logic [31:0] mem_data = 32'h0000_0000, float_pat = 32'h5A5A_A5A5;
    logic [6:0] mem_check = 7'h00;
    int miscompares = 0, n_compared = 0, j, k;

    wedc_ctrl #(.SETTLE_CYC(5)) i_dut (.*);
    wedc_edac_model i_dev (.*);

    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) float_pat <= ~float_pat;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    // Runs a command and checks the masked status.
    task automatic run(input logic [2:0] cmd, input logic [31:0] sm, input logic [31:0] exp);
        apb(1'b1, `WEDC_OFF_CTRL, {24'h00_0000, m, 1'b0, cmd});
        for (int i = 0; i < 100; i++) begin
            rd(`WEDC_OFF_STATUS);
            if (rdat[1] === 1'b1) break;
        end
        chk(rdat & sm, exp);
    endtask : run

    task give_verdict;
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    initial begin
        j = $urandom(29022);
        m = 4'h0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(`WEDC_OFF_STATUS);
        chk(rdat, 32'h0000_0000);
        rd(`WEDC_OFF_RDATA);
        chk(rdat, 32'h0000_0000);
        rd(8'h1C);
        chk({rdat[30:0], rerr}, 32'h0000_0001);
        apb(1'b1, `WEDC_OFF_STATUS, 32'hFFFF_FFFF);
        chk(32'(rerr), 32'h0000_0001);
        apb(1'b1, `WEDC_OFF_WCHECK, 32'hFFFF_FFFF);
        rd(`WEDC_OFF_WCHECK);
        chk(rdat, 32'h0000_007F);
        run(3'h5, 32'h0000_000F, 32'h0000_0002);
        good = $urandom;
        apb(1'b1, `WEDC_OFF_WDATA, good);
        run(3'h2, 32'h0000_000F, 32'h0000_0002);
        rd(`WEDC_OFF_RCHECK);
        chk(rdat, 32'(i_dev.gen(good)));
        // Clean, data bit, check bit, double and all-zero memory words.
        for (int t = 0; t < 5; t++) begin
            j = $urandom_range(31);
            k = $urandom_range(6);
            case (t)
                1: mem_data <= good ^ (32'h0000_0001 << j);
                3: mem_data <= good ^ (32'h0000_0003 << k);
                4: mem_data <= 32'h0000_0000;
                default: mem_data <= good;
            endcase
            mem_check <= (t == 4) ? 7'h00 : i_dev.gen(good) ^ ((t == 2) ? (7'h01 << k) : 7'h00);
            if (t == 0) ec = i_dev.gen(good);
            else if (t == 1) ec = ~i_dev.col[j];
            else if (t == 2) ec = ~(7'h01 << k);
            run(3'h1, 32'h0000_000F, 32'(st_tab[t]));
            rd(`WEDC_OFF_RDATA);
            chk(rdat, good);
            rd(`WEDC_OFF_RCHECK);
            chk(rdat, 32'(ec));
        end
        // Byte merge over a word that needed correction.
        wd = $urandom;
        m = 4'($urandom_range(14, 1));
        mem_data <= good ^ (32'h0000_0001 << j);
        mem_check <= i_dev.gen(good);
        apb(1'b1, `WEDC_OFF_WDATA, wd);
        run(3'h3, 32'h0000_000F, 32'h0000_0006);
        for (int b = 0; b < 4; b++) begin
            exp_d[8 * b +: 8] = m[b] ? wd[8 * b +: 8] : good[8 * b +: 8];
        end
        rd(`WEDC_OFF_RDATA);
        chk(rdat, exp_d);
        rd(`WEDC_OFF_RCHECK);
        chk(rdat, 32'(i_dev.gen(exp_d)));
        // Diagnostic words against a known check word.
        m = 4'h0;
        apb(1'b1, `WEDC_OFF_WDATA, good);
        apb(1'b1, `WEDC_OFF_WCHECK, 32'(i_dev.gen(good)));
        apb(1'b1, `WEDC_OFF_DDATA, good ^ (32'h0000_0001 << j));
        run(3'h4, 32'h0000_0033, 32'h0000_0012);
        rd(`WEDC_OFF_RDATA);
        chk(rdat, good);
        rd(`WEDC_OFF_RCHECK);
        chk(rdat, {25'h000_0000, ~i_dev.col[j]});
        apb(1'b1, `WEDC_OFF_DDATA, good ^ (32'h0000_0003 << k));
        run(3'h4, 32'h0000_0033, 32'h0000_0032);
        give_verdict();
    end
endmodule : wedc_ctrl_tb_top

`default_nettype wire
